// File: hw/hsw_watchdog.sv
// Host supervision watchdog with its configuration register.
// Assumes a register strobe port on sys_clk from the serial bridge and an
// asynchronous GPIO restart pin.
`include "hsw_map.svh"

// Operation
// - Three timeout actions from two-bit action field.
// - Default action sets flag, drives output low.
// - Inhibit action: 300 ms pulse, then standby.
// - Reset action: 300 ms reset-output pulse.
// - Timeouts 60 ms, 600 ms, 3 s, 6 s.
// - Bits 29:28 select timeout, 01 is 600 ms.
// - Bits 17:16 select action, 10 is inhibit.
// - Bit 27 selects 40 MHz divider, else 20.
// - Serial kick accepted once enable bit set; GPIO restart optional.
// - Configuration register resets to 0xc8000468.
// - Timer idle until first restart event.
// - Reaching timeout performs selected action.
// - Kick while running clears counter to zero.
// - Timeout also sets watchdog interrupt flag.
module hsw_watchdog import hsw_pkg::*; #(
   parameter int TICK_CYC_40 = `HSW_TICK_NS / `HSW_SYS_PERIOD_NS,
   parameter int TICK_CYC_20 = `HSW_TICK_NS / (`HSW_SYS_PERIOD_NS * 2),
   parameter int MS_W = 13
) (
   // Clock, reset, enable
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic ce,
   // Register strobe port
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [15:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   output logic [31:0] reg_rdata_q,
   // Restart pin and flag clear
   input wire logic gpio_restart,
   input wire logic irq_flag_clr,
   // Timeout outputs
   output logic irq_flag_q,
   output logic wd_out_n_q,
   output logic inhibit_output_q,
   output logic supervision_restart_bit_out_q,
   output logic standby_req_q
);

   localparam int DIV_W = 16;

   initial begin
      if (TICK_CYC_40 < 2 || TICK_CYC_40 >= (1 << DIV_W) || TICK_CYC_20 < 2
          || TICK_CYC_20 >= (1 << DIV_W)) begin
         $error("hsw_watchdog: tick cycle counts out of range");
      end
      if (MS_W < 13) begin
         $error("hsw_watchdog: MS_W too small for 6 s timeout");
      end
   end

   // ==========================================================
   // Configuration register
   logic [31:0] cfg_q;
   logic cfg_wr, kick, supervision_enable_bit, gpio_en;
   hsw_action_t timeout_action_field;

   assign cfg_wr = reg_wr && (reg_addr == `HSW_CFG_OFS);
   assign kick = cfg_wr && reg_wdata[`HSW_KICK_BIT];
   assign supervision_enable_bit = cfg_q[`HSW_EN_BIT];
   assign gpio_en = cfg_q[`HSW_GPIO_EN_BIT];
   assign timeout_action_field = hsw_action_t'(cfg_q[`HSW_ACT_HI:`HSW_ACT_LO]);

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         cfg_q <= `HSW_CFG_RST;
      end else if (ce && cfg_wr) begin
         cfg_q <= reg_wdata;
         cfg_q[`HSW_KICK_BIT] <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         reg_rdata_q <= 32'h0000_0000;
      end else if (ce && reg_rd) begin
         reg_rdata_q <= (reg_addr == `HSW_CFG_OFS) ? cfg_q : 32'h0000_0000;
      end
   end

   // ==========================================================
   // GPIO restart synchroniser and edge detect
   logic gpio_s1_q, gpio_s2_q, gpio_s3_q, gpio_pulse, restart;

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         gpio_s1_q <= 1'b0;
         gpio_s2_q <= 1'b0;
         gpio_s3_q <= 1'b0;
      end else if (ce) begin
         gpio_s1_q <= gpio_restart;
         gpio_s2_q <= gpio_s1_q;
         gpio_s3_q <= gpio_s2_q;
      end
   end

   assign gpio_pulse = gpio_s2_q && !gpio_s3_q;
   assign restart = kick || (gpio_en && gpio_pulse);

   // ==========================================================
   // Millisecond tick
   logic tick;
   logic [DIV_W-1:0] tick_div;
   hsw_state_t state_q;

   assign tick_div = cfg_q[`HSW_REF40_BIT] ? DIV_W'(TICK_CYC_40 - 1)
                                           : DIV_W'(TICK_CYC_20 - 1);

   hsw_tick_gen #(.DIV_W(DIV_W)) u_tick (
      .sys_clk(sys_clk),
      .rst(rst),
      .ce(ce),
      // Keeps ticking through an action pulse so that its width is timed
      .clear(restart || (state_q != HSW_RUN && !inhibit_output_q && !supervision_restart_bit_out_q)),
      .div(tick_div),
      .tick(tick)
   );

   // ==========================================================
   // Supervision timer
   logic [MS_W-1:0] ms_cnt_q, tmo_limit;
   logic timeout;

   always_comb begin
      unique case (cfg_q[`HSW_TMO_HI:`HSW_TMO_LO])
         2'b00: tmo_limit = MS_W'(`HSW_TMO0_MS);
         2'b01: tmo_limit = MS_W'(`HSW_TMO1_MS);
         2'b10: tmo_limit = MS_W'(`HSW_TMO2_MS);
         2'b11: tmo_limit = MS_W'(`HSW_TMO3_MS);
      endcase
   end

   assign timeout = supervision_enable_bit && state_q == HSW_RUN && !restart && tick
                    && (ms_cnt_q + 1'b1 >= tmo_limit);

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         state_q <= HSW_IDLE;
         ms_cnt_q <= '0;
      end else if (ce) begin
         if (!supervision_enable_bit) begin
            state_q <= HSW_IDLE;
            ms_cnt_q <= '0;
         end else if (restart) begin
            state_q <= HSW_RUN;
            ms_cnt_q <= '0;
         end else if (timeout) begin
            state_q <= HSW_IDLE;
            ms_cnt_q <= '0;
         end else if (state_q == HSW_RUN && tick) begin
            ms_cnt_q <= ms_cnt_q + 1'b1;
         end
      end
   end

   // ==========================================================
   // Interrupt flag and watchdog output pin
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         irq_flag_q <= 1'b0;
         wd_out_n_q <= 1'b1;
      end else if (ce) begin
         if (timeout) begin
            irq_flag_q <= 1'b1;
         end else if (irq_flag_clr) begin
            irq_flag_q <= 1'b0;
         end
         if (timeout && timeout_action_field != HSW_ACT_RESET
             && timeout_action_field != HSW_ACT_INHIBIT) begin
            wd_out_n_q <= 1'b0;
         end else if (irq_flag_clr || restart) begin
            wd_out_n_q <= 1'b1;
         end
      end
   end

   // ==========================================================
   // 300 ms action pulses
   logic [MS_W-1:0] pulse_cnt_q;
   logic pulse_end;

   assign pulse_end = (inhibit_output_q || supervision_restart_bit_out_q) && tick
                      && (pulse_cnt_q + 1'b1 >= MS_W'(`HSW_PULSE_MS));

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         inhibit_output_q <= 1'b0;
         supervision_restart_bit_out_q <= 1'b0;
         standby_req_q <= 1'b0;
         pulse_cnt_q <= '0;
      end else if (ce) begin
         standby_req_q <= 1'b0;
         if (!supervision_enable_bit) begin
            inhibit_output_q <= 1'b0;
            supervision_restart_bit_out_q <= 1'b0;
            pulse_cnt_q <= '0;
         end else if (timeout) begin
            inhibit_output_q <= (timeout_action_field == HSW_ACT_INHIBIT);
            supervision_restart_bit_out_q <= (timeout_action_field == HSW_ACT_RESET);
            pulse_cnt_q <= '0;
         end else if (pulse_end) begin
            standby_req_q <= inhibit_output_q;
            inhibit_output_q <= 1'b0;
            supervision_restart_bit_out_q <= 1'b0;
            pulse_cnt_q <= '0;
         end else if ((inhibit_output_q || supervision_restart_bit_out_q) && tick) begin
            pulse_cnt_q <= pulse_cnt_q + 1'b1;
         end
      end
   end

   // ==========================================================
   // Assertions
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);

   sequence kick_taken_s;
      ce && kick && supervision_enable_bit;
   endsequence

   sequence timeout_s;
      ce && timeout;
   endsequence

   kick_clears_a: assert property (kick_taken_s |=> ms_cnt_q == '0 && state_q == HSW_RUN)
      else $error("kick did not clear counter");
   idle_no_count_a: assert property (state_q == HSW_IDLE |-> ms_cnt_q == '0)
      else $error("counter moved while idle");
   disabled_hold_a: assert property (ce && !supervision_enable_bit |=>
         state_q == HSW_IDLE && !inhibit_output_q && !supervision_restart_bit_out_q)
      else $error("disabled watchdog not idle");
   flag_on_tmo_a: assert property (timeout_s |=> irq_flag_q)
      else $error("timeout did not set flag");
   inhibit_start_a: assert property (timeout_s ##0 timeout_action_field == HSW_ACT_INHIBIT
         |=> inhibit_output_q && !supervision_restart_bit_out_q)
      else $error("inhibit pulse did not start");
   reset_start_a: assert property (timeout_s ##0 timeout_action_field == HSW_ACT_RESET
         |=> supervision_restart_bit_out_q && !inhibit_output_q)
      else $error("reset pulse did not start");
   irq_pin_low_a: assert property (timeout_s ##0 timeout_action_field == HSW_ACT_IRQ
         |=> !wd_out_n_q && !inhibit_output_q)
      else $error("watchdog pin not low");
   standby_after_a: assert property (ce && pulse_end && inhibit_output_q
         |=> standby_req_q && !inhibit_output_q)
      else $error("no standby after inhibit pulse");
   cfg_reset_a: assert property ($fell(rst) |-> cfg_q == `HSW_CFG_RST)
      else $error("config reset value wrong");
   tmo_limit_a: assert property (timeout_s |-> ms_cnt_q + 1'b1 == tmo_limit)
      else $error("timeout at wrong count");

endmodule // hsw_watchdog

// File: hw/hsw_map.svh
// Register offset, field positions, reset value and timing counts of the
// host supervision watchdog. Assumes inclusion by the watchdog design files.
`ifndef HSW_MAP_SVH
`define HSW_MAP_SVH

// ==========================================================
// Register map
`define HSW_CFG_OFS 16'h0800
`define HSW_CFG_RST 32'hc8000468

// ==========================================================
// Field positions
`define HSW_TMO_HI 29
`define HSW_TMO_LO 28
`define HSW_REF40_BIT 27
`define HSW_GPIO_EN_BIT 19
`define HSW_KICK_BIT 18
`define HSW_ACT_HI 17
`define HSW_ACT_LO 16
`define HSW_EN_BIT 3

// ==========================================================
// Timing, in the units given by each name
`define HSW_SYS_PERIOD_NS 25
`define HSW_TICK_NS 1000000
`define HSW_TMO0_MS 60
`define HSW_TMO1_MS 600
`define HSW_TMO2_MS 3000
`define HSW_TMO3_MS 6000
`define HSW_PULSE_MS 300

`endif

// File: hw/hsw_pkg.sv
// Types shared by the host supervision watchdog.
// Assumes nothing of its surroundings.
package hsw_pkg;

   // ==========================================================
   // Timeout action codes
   typedef enum logic [1:0] {
      HSW_ACT_IRQ = 2'b00,
      HSW_ACT_RESET = 2'b01,
      HSW_ACT_INHIBIT = 2'b10,
      HSW_ACT_SPARE = 2'b11
   } hsw_action_t;

   // ==========================================================
   // Timer states
   typedef enum logic {
      HSW_IDLE,
      HSW_RUN
   } hsw_state_t;

endpackage

// File: hw/hsw_tick_gen.sv
// Millisecond tick prescaler of the watchdog.
// Assumes clear, ce and div come from logic on sys_clk.
module hsw_tick_gen #(
   parameter int DIV_W = 16
) (
   // Clock and control
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic ce,
   input wire logic clear,
   // Cycles per tick, minus one
   input wire logic [DIV_W-1:0] div,
   // One-cycle tick
   output logic tick
);

   initial begin
      if (DIV_W < 2 || DIV_W > 31) begin
         $error("hsw_tick_gen: DIV_W out of range");
      end
   end

   logic [DIV_W-1:0] cnt_q;

   always_ff @(posedge sys_clk) begin
      if (rst || clear) begin
         cnt_q <= '0;
         tick <= 1'b0;
      end else if (ce) begin
         tick <= (cnt_q == div);
         cnt_q <= (cnt_q == div) ? '0 : cnt_q + 1'b1;
      end
   end

endmodule // hsw_tick_gen

// File: tb/hsw_host_model.sv
// Host side of the supervision watchdog: register strobes and GPIO restart.
// Assumes the watchdog samples on rising sys_clk; all drive is on the falling edge.
module hsw_host_model (
   // Clock
   input wire logic sys_clk,
   // Register port
   output logic reg_wr = 1'b0,
   output logic reg_rd = 1'b0,
   output logic [15:0] reg_addr = 16'h0000,
   output logic [31:0] reg_wdata = 32'h00000000,
   input wire logic [31:0] reg_rdata_q,
   // Restart pin
   output logic gpio_restart = 1'b0
);
   timeunit 1ns;
   timeprecision 100ps;

   // ==========================================
   // Settings word with the enable bit chosen by the caller
   function automatic logic [31:0] cfg(input logic [1:0] t, input logic r, g, k,
      input logic [1:0] a, input logic e);
      return (32'hc8000468 & ~32'h380f0008) | {2'h0, t, r, 7'h00, g, k, a, 12'h000, e, 3'h0};
   endfunction

   // ==========================================
   // Bus cycles; released lines carry the inverse of the last value
   task automatic wr(input logic [15:0] a, input logic [31:0] d);
      @(negedge sys_clk);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(negedge sys_clk);
      reg_wr = 1'b0;
      reg_addr = ~a;
      reg_wdata = ~d;
   endtask

   task automatic rd(input logic [15:0] a, output logic [31:0] d);
      @(negedge sys_clk);
      reg_addr = a;
      reg_rd = 1'b1;
      @(negedge sys_clk);
      reg_rd = 1'b0;
      reg_addr = ~a;
      d = reg_rdata_q;
   endtask

   task automatic pulse();
      @(negedge sys_clk);
      gpio_restart = 1'b1;
      repeat (4) @(negedge sys_clk);
      gpio_restart = 1'b0;
   endtask
endmodule // hsw_host_model

// File: tb/test_host_supervision_watchdog.sv
// Self-checking bench of the host supervision watchdog.
// Assumes short tick counts: 8 cycles per tick at 40 MHz reference, 4 at 20 MHz.
module test_host_supervision_watchdog;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int T40 = 8;
   localparam int T20 = 4;
   localparam logic [15:0] CFG = 16'h0800;
   logic sys_clk = 1'b0;
   logic rst = 1'b1;
   logic ce = 1'b1;
   logic irq_flag_clr = 1'b0;
   logic reg_wr, reg_rd, gpio_restart, irq_flag_q, wd_out_n_q;
   logic inhibit_output_q, supervision_restart_bit_out_q, standby_req_q;
   logic [15:0] reg_addr;
   logic [31:0] reg_wdata, reg_rdata_q, v;
   int err_total = 0;
   int n_checks = 0;
   int n;
   int s;

   always #12.5 sys_clk = ~sys_clk;

   hsw_watchdog #(.TICK_CYC_40(T40), .TICK_CYC_20(T20), .MS_W(13)) i_dut (.sys_clk(sys_clk),
      .rst(rst), .ce(ce), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q), .gpio_restart(gpio_restart),
      .irq_flag_clr(irq_flag_clr), .irq_flag_q(irq_flag_q), .wd_out_n_q(wd_out_n_q),
      .inhibit_output_q(inhibit_output_q), .supervision_restart_bit_out_q(supervision_restart_bit_out_q),
      .standby_req_q(standby_req_q));

   hsw_host_model i_host (.sys_clk(sys_clk), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q),
      .gpio_restart(gpio_restart));

   // ==========================================
   // Checking and closing
   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("wrong value %s exp %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic wrap_up();
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask

   task automatic wait_irq(input int lim);
      n = 0;
      while (irq_flag_q !== 1'b1 && n < lim) begin
         @(negedge sys_clk);
         n++;
      end
      if (n >= lim) begin
         check("irq wait", 0, 1);
         wrap_up();
      end
   endtask

   task automatic clr();
      @(negedge sys_clk);
      irq_flag_clr = 1'b1;
      @(negedge sys_clk);
      irq_flag_clr = 1'b0;
   endtask

   // ==========================================
   // Scenarios
   task automatic t_reset();
      i_host.rd(CFG, v);
      check("cfg reset", v, 32'hc8000468);
      repeat (600) @(negedge sys_clk);
      check("idle irq", irq_flag_q, 0);
      i_host.rd(16'h0804, v);
      check("unmapped", v, 0);
      i_host.wr(CFG, i_host.cfg(2'h0, 1'b1, 1'b0, 1'b1, 2'h0, 1'b0));
      i_host.rd(CFG, v);
      check("readback", v, i_host.cfg(2'h0, 1'b1, 1'b0, 1'b0, 2'h0, 1'b0));
      repeat (600) @(negedge sys_clk);
      check("off irq", irq_flag_q, 0);
      $display("test reset done");
   endtask

   task automatic t_timeouts();
      int ms[4] = '{60, 600, 3000, 6000};
      int t;
      // A kick only counts once the enable bit already stands
      i_host.wr(CFG, i_host.cfg(2'h0, 1'b1, 1'b0, 1'b0, 2'h0, 1'b1));
      for (int i = 0; i < 4; i++) begin
         t = (i < 2) ? T40 : T20;
         i_host.wr(CFG, i_host.cfg(2'(i), i < 2, 1'b0, 1'b1, (i == 3) ? 2'h3 : 2'h0, 1'b1));
         wait_irq(ms[i] * t + 2 * t + 10);
         check("period", n >= ms[i] * t - t && n <= ms[i] * t + t + 3, 1);
         check("wd out", wd_out_n_q, 0);
         clr();
         check("flag clr", {irq_flag_q, wd_out_n_q}, 2'h1);
      end
      $display("test timeouts done");
   endtask

   task automatic t_freeze();
      i_host.wr(CFG, i_host.cfg(2'h0, 1'b1, 1'b0, 1'b1, 2'h0, 1'b1));
      @(negedge sys_clk);
      ce = 1'b0;
      repeat (1000) @(negedge sys_clk);
      check("frozen irq", irq_flag_q, 0);
      ce = 1'b1;
      wait_irq(60 * T40 + 2 * T40 + 10);
      check("frozen period", n >= 59 * T40 && n <= 61 * T40, 1);
      clr();
      $display("test freeze done");
   endtask

   task automatic t_pulse(input logic [1:0] a);
      i_host.wr(CFG, i_host.cfg(2'h0, 1'b1, 1'b0, 1'b1, a, 1'b1));
      wait_irq(600);
      check("pulses", {supervision_restart_bit_out_q, inhibit_output_q}, (a == 2'h1) ? 2'h2 : 2'h1);
      n = 0;
      while ((supervision_restart_bit_out_q | inhibit_output_q) === 1'b1 && n < 4000) begin
         @(negedge sys_clk);
         n++;
      end
      check("width", n >= 300 * T40 - T40 && n <= 300 * T40 + 2, 1);
      s = 0;
      repeat (3) begin
         s += int'(standby_req_q);
         @(negedge sys_clk);
      end
      check("standby", 32'(s), (a == 2'h2) ? 1 : 0);
      check("wd out", wd_out_n_q, 1);
      clr();
      $display("test pulse done");
   endtask

   task automatic t_restart(input logic gp, input logic en);
      v = i_host.cfg(2'h0, 1'b1, en, 1'b1, 2'h0, 1'b1);
      i_host.wr(CFG, v);
      repeat (4) begin
         repeat (300) @(negedge sys_clk);
         if (gp) i_host.pulse();
         else i_host.wr(CFG, v);
      end
      check("restart", irq_flag_q, gp & ~en);
      clr();
      $display("test restart done");
   endtask

   initial begin
      repeat (20) @(negedge sys_clk);
      rst = 1'b0;
      t_reset();
      t_timeouts();
      t_freeze();
      t_pulse(2'h1);
      t_pulse(2'h2);
      t_restart(1'b0, 1'b1);
      t_restart(1'b1, 1'b1);
      t_restart(1'b1, 1'b0);
      wrap_up();
   end
endmodule // test_host_supervision_watchdog
